// [src/dopwm_pkg.sv]
package dopwm_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [3:0] DOPWM_OFS_ENABLE = 4'h0;
  localparam logic [3:0] DOPWM_OFS_CTRL   = 4'h1;
  localparam logic [3:0] DOPWM_OFS_PER_LO = 4'h2;
  localparam logic [3:0] DOPWM_OFS_PER_HI = 4'h3;
  localparam logic [3:0] DOPWM_OFS_DUT_LO = 4'h4;
  localparam logic [3:0] DOPWM_OFS_DUT_HI = 4'h5;
  localparam logic [3:0] DOPWM_OFS_DT_LO  = 4'h6;
  localparam logic [3:0] DOPWM_OFS_DT_HI  = 4'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DOPWM_EN_CHAN   = 0;
  localparam int DOPWM_EN_POUT   = 1;
  localparam int DOPWM_EN_SOUT   = 2;
  localparam int DOPWM_EN_MODE   = 3;
  localparam int DOPWM_EN_FDET   = 4;
  localparam int DOPWM_EN_FPRE   = 5;
  localparam int DOPWM_C_CLKDIV  = 0;
  localparam int DOPWM_C_OPOL    = 2;
  localparam int DOPWM_C_FPOL    = 4;
  localparam int DOPWM_C_FSTAT   = 5;
  localparam int DOPWM_C_IFLAG   = 6;
  localparam int DOPWM_C_IEN     = 7;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0] DOPWM_RST_BYTE = 8'h00;
  localparam logic [7:0] DOPWM_EN_WMASK = 8'h7f;
  localparam logic [7:0] DOPWM_HI_WMASK = 8'h0f;
  localparam logic [11:0] DOPWM_CNT_START = 12'h001;

  // ****************************************************************
  // Prescaler terminal counts, divide by 1, 8, 32, 128
  // ****************************************************************
  localparam logic [6:0] DOPWM_DIV1_TC   = 7'h00;
  localparam logic [6:0] DOPWM_DIV8_TC   = 7'h07;
  localparam logic [6:0] DOPWM_DIV32_TC  = 7'h1f;
  localparam logic [6:0] DOPWM_DIV128_TC = 7'h7f;

  typedef enum logic [1:0] {
    DOPWM_ST_IDLE = 2'b01,
    DOPWM_ST_RUN  = 2'b10
  } dopwm_state_t;

endpackage

// [src/dopwm_tick_if.sv]
interface dopwm_tick_if;
  logic       run;
  logic [1:0] divsel;
  logic       tick;
  modport ctrl (output run, output divsel, input tick);
  modport gen  (input run, input divsel, output tick);
endinterface

// [src/dopwm_prescaler.sv]
module dopwm_prescaler
  import dopwm_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  dopwm_tick_if.gen tk
);

  logic [6:0] div_r;
  logic [6:0] div_nxt;
  logic [6:0] tc;
  logic       hit;

  // Divider selection by the counter clock field.
  assign tc = (tk.divsel == 2'b00) ? DOPWM_DIV1_TC :
              (tk.divsel == 2'b01) ? DOPWM_DIV8_TC :
              (tk.divsel == 2'b10) ? DOPWM_DIV32_TC : DOPWM_DIV128_TC;
  assign hit     = tk.run && (div_r >= tc);
  assign div_nxt = (!tk.run || hit) ? 7'h00 : div_r + 7'h01;
  assign tk.tick = hit;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= 7'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

endmodule

// [src/dopwm_channel.sv]
// Operation
// - Fault preset code forces both output levels.
// - Fault detect enable turns fault input on.
// - Mode bit: complementary or independent pairing.
// - Secondary enable gates the secondary output.
// - Primary output needs channel enable too.
// - Counter runs with outputs disabled too.
// - Output enable changes act immediately.
// - Channel disable stops counter, outputs off.
// - Channel enable restarts counter from one.
// - Interrupt enable gates interrupt request.
// - Overflow sets flag; software writes zero.
// - Fault sets status; software writes zero.
// - Fault polarity picks active fault level.
// - Polarity field sets output active levels.
// - Active windows per pairing mode.
// - Clock select divides by 1/8/32/128.
// - Period is twelve bits, low plus nibble.
// - Period high upper bits read zero.
// - New period armed by low write.
// - Period equals value times counter clock.
// - Duty (less dead time if complementary) times clock, next period.
// - Dead time separates complementary edges.
// - Independent mode: dead time is secondary duty.
module dopwm_channel
  import dopwm_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       fault_input_pin_i,
  output logic            primary_output_o,
  output logic            primary_output_oe_o,
  output logic            secondary_output_o,
  output logic            secondary_output_oe_o,
  output logic            irq_o
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0]   en_r;
  logic [7:0]   ctl_r;
  logic [7:0]   per_lo_r;
  logic [3:0]   per_hi_r;
  logic [7:0]   dut_lo_r;
  logic [3:0]   dut_hi_r;
  logic [7:0]   dt_lo_r;
  logic [3:0]   dt_hi_r;
  logic [11:0]  per_act_r;
  logic [11:0]  dut_act_r;
  logic [11:0]  dt_act_r;
  logic         per_pend_r;
  logic         dut_pend_r;
  logic         dt_pend_r;
  logic [11:0]  cnt_r;
  logic [11:0]  cnt_nxt;
  logic [7:0]   rdata_r;
  logic [7:0]   rdata_nxt;
  logic         pri_r;
  logic         sec_r;
  logic         pri_oe_r;
  logic         sec_oe_r;
  dopwm_state_t st_r;
  dopwm_state_t st_nxt;

  dopwm_tick_if tk ();

  dopwm_prescaler u_presc (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .tk        (tk)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic w_en;
  logic w_ctl;
  logic w_plo;
  logic w_phi;
  logic w_dlo;
  logic w_dhi;
  logic w_tlo;
  logic w_thi;
  assign w_en  = wr_i && (addr_i == DOPWM_OFS_ENABLE);
  assign w_ctl = wr_i && (addr_i == DOPWM_OFS_CTRL);
  assign w_plo = wr_i && (addr_i == DOPWM_OFS_PER_LO);
  assign w_phi = wr_i && (addr_i == DOPWM_OFS_PER_HI);
  assign w_dlo = wr_i && (addr_i == DOPWM_OFS_DUT_LO);
  assign w_dhi = wr_i && (addr_i == DOPWM_OFS_DUT_HI);
  assign w_tlo = wr_i && (addr_i == DOPWM_OFS_DT_LO);
  assign w_thi = wr_i && (addr_i == DOPWM_OFS_DT_HI);

  logic       chan_en;
  logic       pout_en;
  logic       sout_en;
  logic       indep;
  logic       fdet_en;
  logic [1:0] fpre;
  logic [1:0] opol;
  logic       fpol;
  logic       fstat;
  logic       iflag;
  logic       ien;
  assign chan_en = en_r[DOPWM_EN_CHAN];
  assign pout_en = en_r[DOPWM_EN_POUT];
  assign sout_en = en_r[DOPWM_EN_SOUT];
  assign indep   = en_r[DOPWM_EN_MODE];
  assign fdet_en = en_r[DOPWM_EN_FDET];
  assign fpre    = en_r[DOPWM_EN_FPRE +: 2];
  assign opol    = ctl_r[DOPWM_C_OPOL +: 2];
  assign fpol    = ctl_r[DOPWM_C_FPOL];
  assign fstat   = ctl_r[DOPWM_C_FSTAT];
  assign iflag   = ctl_r[DOPWM_C_IFLAG];
  assign ien     = ctl_r[DOPWM_C_IEN];

  // ****************************************************************
  // Counter control
  // ****************************************************************
  logic running;
  logic start;
  logic ovf;
  assign running = (st_r == DOPWM_ST_RUN);
  assign start   = (st_r == DOPWM_ST_IDLE) && chan_en;
  assign tk.run    = running && chan_en;
  assign tk.divsel = ctl_r[DOPWM_C_CLKDIV +: 2];
  assign ovf       = tk.run && tk.tick && (cnt_r >= per_act_r);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DOPWM_ST_IDLE: if (chan_en) st_nxt = DOPWM_ST_RUN;
      DOPWM_ST_RUN:  if (!chan_en) st_nxt = DOPWM_ST_IDLE;
      default:       st_nxt = DOPWM_ST_IDLE;
    endcase
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (!chan_en || start) begin
      cnt_nxt = DOPWM_CNT_START;
    end else if (ovf) begin
      cnt_nxt = DOPWM_CNT_START;
    end else if (tk.run && tk.tick) begin
      cnt_nxt = cnt_r + 12'h001;
    end
  end

  // ****************************************************************
  // Fault and flags
  // ****************************************************************
  logic fault_seen;
  logic fault_hold;
  assign fault_seen = fdet_en && chan_en && (fault_input_pin_i == fpol);
  assign fault_hold = fdet_en && fstat;

  logic [7:0] ctl_nxt;
  always_comb begin
    ctl_nxt = ctl_r;
    if (w_ctl) begin
      // Flags only accept a zero from software; a one written is ignored.
      ctl_nxt = {wdata_i[7], ctl_r[6] & wdata_i[6], ctl_r[5] & wdata_i[5], wdata_i[4:0]};
    end
    // Hardware set wins over a clear in the same cycle.
    if (ovf) ctl_nxt[DOPWM_C_IFLAG] = 1'b1;
    if (fault_seen) ctl_nxt[DOPWM_C_FSTAT] = 1'b1;
  end

  assign irq_o = ien && iflag;

  // ****************************************************************
  // Waveform generation
  // ****************************************************************
  logic pri_act;
  logic sec_act;
  logic pri_lvl;
  logic sec_lvl;
  logic pri_nxt;
  logic sec_nxt;
  logic [12:0] dd_sum;
  assign dd_sum = {1'b0, dut_act_r} + {1'b0, dt_act_r};
  // Primary active for duty; in complementary mode it starts after the
  // dead time so both edges keep a gap, at the cost of a shorter pulse.
  assign pri_act = indep ? (cnt_r <= dut_act_r) :
                   ((cnt_r > dt_act_r) && (cnt_r <= dut_act_r));
  assign sec_act = indep ? (cnt_r <= dt_act_r) :
                   ({1'b0, cnt_r} > dd_sum);
  assign pri_lvl = pri_act ^ opol[1];
  assign sec_lvl = sec_act ^ opol[0];
  always_comb begin
    pri_nxt = pri_lvl;
    sec_nxt = sec_lvl;
    if (fault_hold || fault_seen) begin
      pri_nxt = fpre[1];
      sec_nxt = fpre[0];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    case (addr_i)
      DOPWM_OFS_ENABLE: rdata_nxt = en_r;
      DOPWM_OFS_CTRL:   rdata_nxt = ctl_r;
      DOPWM_OFS_PER_LO: rdata_nxt = per_lo_r;
      DOPWM_OFS_PER_HI: rdata_nxt = {4'h0, per_hi_r};
      DOPWM_OFS_DUT_LO: rdata_nxt = dut_lo_r;
      DOPWM_OFS_DUT_HI: rdata_nxt = {4'h0, dut_hi_r};
      DOPWM_OFS_DT_LO:  rdata_nxt = dt_lo_r;
      DOPWM_OFS_DT_HI:  rdata_nxt = {4'h0, dt_hi_r};
      default:          rdata_nxt = DOPWM_RST_BYTE;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] en_nxt;
  logic [7:0] per_lo_nxt;
  logic [3:0] per_hi_nxt;
  logic [7:0] dut_lo_nxt;
  logic [3:0] dut_hi_nxt;
  logic [7:0] dt_lo_nxt;
  logic [3:0] dt_hi_nxt;
  assign en_nxt     = w_en  ? (wdata_i & DOPWM_EN_WMASK) : en_r;
  assign per_lo_nxt = w_plo ? wdata_i : per_lo_r;
  assign per_hi_nxt = w_phi ? wdata_i[3:0] : per_hi_r;
  assign dut_lo_nxt = w_dlo ? wdata_i : dut_lo_r;
  assign dut_hi_nxt = w_dhi ? wdata_i[3:0] : dut_hi_r;
  assign dt_lo_nxt  = w_tlo ? wdata_i : dt_lo_r;
  assign dt_hi_nxt  = w_thi ? wdata_i[3:0] : dt_hi_r;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_r     <= DOPWM_RST_BYTE;
      ctl_r    <= DOPWM_RST_BYTE;
      per_lo_r <= DOPWM_RST_BYTE;
      per_hi_r <= 4'h0;
      dut_lo_r <= DOPWM_RST_BYTE;
      dut_hi_r <= 4'h0;
      dt_lo_r  <= DOPWM_RST_BYTE;
      dt_hi_r  <= 4'h0;
    end else begin
      en_r     <= en_nxt;
      ctl_r    <= ctl_nxt;
      per_lo_r <= per_lo_nxt;
      per_hi_r <= per_hi_nxt;
      dut_lo_r <= dut_lo_nxt;
      dut_hi_r <= dut_hi_nxt;
      dt_lo_r  <= dt_lo_nxt;
      dt_hi_r  <= dt_hi_nxt;
    end
  end

  // Shadow values load only at overflow or at a fresh start, so a
  // half-written value never reaches the compare logic.
  logic        load_ev;
  logic        per_pend_nxt;
  logic        dut_pend_nxt;
  logic        dt_pend_nxt;
  logic [11:0] per_act_nxt;
  logic [11:0] dut_act_nxt;
  logic [11:0] dt_act_nxt;
  assign load_ev      = ovf || start;
  assign per_pend_nxt = w_plo || (per_pend_r && !load_ev);
  assign dut_pend_nxt = w_dlo || (dut_pend_r && !load_ev);
  assign dt_pend_nxt  = w_tlo || (dt_pend_r && !load_ev);
  assign per_act_nxt  = (load_ev && per_pend_r) ? {per_hi_r, per_lo_r} : per_act_r;
  assign dut_act_nxt  = (load_ev && dut_pend_r) ? {dut_hi_r, dut_lo_r} : dut_act_r;
  assign dt_act_nxt   = (load_ev && dt_pend_r) ? {dt_hi_r, dt_lo_r} : dt_act_r;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      per_pend_r <= 1'b0;
      dut_pend_r <= 1'b0;
      dt_pend_r  <= 1'b0;
      per_act_r  <= 12'h000;
      dut_act_r  <= 12'h000;
      dt_act_r   <= 12'h000;
    end else begin
      per_pend_r <= per_pend_nxt;
      dut_pend_r <= dut_pend_nxt;
      dt_pend_r  <= dt_pend_nxt;
      per_act_r  <= per_act_nxt;
      dut_act_r  <= dut_act_nxt;
      dt_act_r   <= dt_act_nxt;
    end
  end

  logic       pri_oe_nxt;
  logic       sec_oe_nxt;
  logic [7:0] rd_out_nxt;
  assign pri_oe_nxt = w_en ? (wdata_i[DOPWM_EN_CHAN] && wdata_i[DOPWM_EN_POUT]) :
                      (chan_en && pout_en);
  assign sec_oe_nxt = w_en ? (wdata_i[DOPWM_EN_CHAN] && wdata_i[DOPWM_EN_SOUT]) :
                      (chan_en && sout_en);
  assign rd_out_nxt = rd_i ? rdata_nxt : DOPWM_RST_BYTE;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r     <= DOPWM_ST_IDLE;
      cnt_r    <= DOPWM_CNT_START;
      rdata_r  <= DOPWM_RST_BYTE;
      pri_r    <= 1'b0;
      sec_r    <= 1'b0;
      pri_oe_r <= 1'b0;
      sec_oe_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      rdata_r  <= rd_out_nxt;
      pri_r    <= pri_nxt;
      sec_r    <= sec_nxt;
      pri_oe_r <= pri_oe_nxt;
      sec_oe_r <= sec_oe_nxt;
    end
  end

  assign rdata_o               = rdata_r;
  assign primary_output_o      = pri_r;
  assign secondary_output_o    = sec_r;
  assign primary_output_oe_o   = pri_oe_r;
  assign secondary_output_oe_o = sec_oe_r;

endmodule

// [tb/dopwm_channel_properties.sv]
module dopwm_channel_chk
  import dopwm_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       fault_input_pin_i,
  input wire logic       primary_output_o,
  input wire logic       primary_output_oe_o,
  input wire logic       secondary_output_o,
  input wire logic       secondary_output_oe_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Shadow of the bus writes, since the checker sees only the ports.
  // ****************************************************************
  logic [7:0] en_r;
  logic       fpol_r;
  logic       ie_r;
  wire        wr_en = wr_i && addr_i == DOPWM_OFS_ENABLE;
  wire        wr_c  = wr_i && addr_i == DOPWM_OFS_CTRL;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_r <= 8'h00;
      fpol_r <= 1'b0;
      ie_r <= 1'b0;
    end else begin
      if (wr_en) en_r <= wdata_i & DOPWM_EN_WMASK;
      if (wr_c) fpol_r <= wdata_i[DOPWM_C_FPOL];
      if (wr_c) ie_r <= wdata_i[DOPWM_C_IEN];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_fault;
    (en_r[4] && en_r[0] && fault_input_pin_i == fpol_r && $stable(en_r))[*4];
  endsequence
  property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_hi_zero; rd_i && addr_i[0] && !addr_i[3] && addr_i != 4'h1 |=> rdata_o[7:4] == 4'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("high bits not zero");
  property p_en_rsvd; rd_i && addr_i == DOPWM_OFS_ENABLE |=> !rdata_o[7]; endproperty
  a_en_rsvd: assert property (p_en_rsvd) else $error("reserved bit set");
  property p_irq_gate; wr_c && !wdata_i[7] |=> !irq_o; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  property p_irq_src; $rose(irq_o) |-> ie_r; endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without enable");
  property p_pri_oe; wr_en |=> ##[0:1] primary_output_oe_o == (en_r[0] && en_r[1]); endproperty
  a_pri_oe: assert property (p_pri_oe) else $error("primary enable wrong");
  property p_sec_oe; wr_en |=> ##[0:1] secondary_output_oe_o == (en_r[0] && en_r[2]); endproperty
  a_sec_oe: assert property (p_sec_oe) else $error("secondary enable wrong");
  property p_fault;
    s_fault |-> primary_output_o == en_r[6] && secondary_output_o == en_r[5];
  endproperty
  a_fault: assert property (p_fault) else $error("fault levels wrong");
endmodule

bind dopwm_channel dopwm_channel_chk dopwm_channel_chk_inst (
  .clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .fault_input_pin_i,
  .primary_output_o, .primary_output_oe_o, .secondary_output_o, .secondary_output_oe_o, .irq_o
);

// [tb/dopwm_load_model.sv]
module dopwm_load_model (
  input  wire logic clk_sys_i,
  input  wire logic pri_i,
  input  wire logic pri_oe_i,
  input  wire logic sec_i,
  input  wire logic sec_oe_i,
  output logic      pri_pin_o,
  output logic      sec_pin_o,
  output int        per_o,
  output int        high_o,
  output int        sec_high_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Gate driver inputs carry pull-downs, so a released pin reads low.
  // ****************************************************************
  int   cnt = 0;
  int   hcnt = 0;
  logic last = 1'b0;
  int   shcnt = 0;
  logic slast = 1'b0;
  assign pri_pin_o = pri_oe_i ? pri_i : 1'b0;
  assign sec_pin_o = sec_oe_i ? sec_i : 1'b0;
  always @(posedge clk_sys_i) begin
    last <= pri_pin_o;
    if (pri_pin_o && !last) begin
      per_o <= cnt;
      cnt <= 1;
      hcnt <= 1;
    end else begin
      cnt <= cnt + 1;
      hcnt <= hcnt + int'(pri_pin_o);
    end
    if (!pri_pin_o && last) high_o <= hcnt;
    slast <= sec_pin_o;
    if (sec_pin_o && !slast) begin
      shcnt <= 1;
    end else begin
      shcnt <= shcnt + int'(sec_pin_o);
    end
    if (!sec_pin_o && slast) sec_high_o <= shcnt;
  end
endmodule

// [tb/dual_output_pwm_channel_tb_top.sv]
module dual_output_pwm_channel_tb_top
  import dopwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        fault_i = 1'b0;
  logic [7:0]  rdata_o;
  logic        pri, pri_oe, sec, sec_oe, irq_o, pri_pin;
  logic [31:0] seed = 32'h0000_4640;
  int          per, high, shigh, mismatches = 0, tests_run = 0, cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  dopwm_channel dopwm_channel_inst (
    .clk_sys_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .fault_input_pin_i(fault_i), .primary_output_o(pri), .primary_output_oe_o(pri_oe),
    .secondary_output_o(sec), .secondary_output_oe_o(sec_oe), .irq_o
  );
  dopwm_load_model dopwm_load_model_inst (
    .clk_sys_i, .pri_i(pri), .pri_oe_i(pri_oe), .sec_i(sec), .sec_oe_i(sec_oe),
    .pri_pin_o(pri_pin), .sec_pin_o(), .per_o(per), .high_o(high), .sec_high_o(shigh)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int divf(input logic [1:0] k);
    return (k == 2'd0) ? 1 : (k == 2'd1) ? 8 : (k == 2'd2) ? 32 : 128;
  endfunction
  function automatic logic [7:0] wmask(input logic [3:0] a);
    if (a[3]) return 8'h00;
    if (a == DOPWM_OFS_ENABLE) return DOPWM_EN_WMASK;
    if (a == DOPWM_OFS_CTRL) return 8'h9f;
    return a[0] ? DOPWM_HI_WMASK : 8'hff;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(32'(rdata_o & m), 32'(e));
  endtask
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A hang costs a mismatch; the longest test needs well under this count.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    logic [7:0]  d;
    logic [11:0] p;
    logic [1:0]  k;
    int          act;
    int          sact;
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) rc(4'(i), 8'hff, 8'h00);
    $display("Test reset values done");
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      d = seed[7:0] & ((i == 0) ? 8'hfe : 8'hff);
      wr(4'(i), d);
      rc(4'(i), 8'hff, d & wmask(4'(i)));
    end
    $display("Test register access done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      k = 2'(i);
      p = 12'(5 + seed[2:0]);
      act = k[0] ? 3 : 2;
      act = (seed[3] ? int'(p) - act : act) * divf(k);
      sact = k[0] ? 1 : int'(p) - 4;
      sact = (seed[4] ? int'(p) - sact : sact) * divf(k);
      wr(DOPWM_OFS_ENABLE, 8'h00);
      wr(DOPWM_OFS_PER_HI, {4'h0, p[11:8]});
      wr(DOPWM_OFS_PER_LO, p[7:0]);
      wr(DOPWM_OFS_DUT_HI, 8'h00);
      wr(DOPWM_OFS_DUT_LO, 8'h03);
      wr(DOPWM_OFS_DT_HI, 8'h00);
      wr(DOPWM_OFS_DT_LO, 8'h01);
      wr(DOPWM_OFS_CTRL, {4'h0, seed[3], seed[4], k});
      wr(DOPWM_OFS_ENABLE, {4'h0, k[0], 3'h7});
      repeat (4) @(posedge pri_pin);
      repeat (2) @(posedge clk_sys_i);
      chk(32'(per), 32'(int'(p) * divf(k)));
      chk(32'(high), 32'(act));
      chk(32'(shigh), 32'(sact));
    end
    $display("Test period and duty done");
    wr(DOPWM_OFS_ENABLE, 8'h01);
    wr(DOPWM_OFS_CTRL, 8'h80);
    for (int i = 0; i < 200 && irq_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk(32'({irq_o, pri_oe, sec_oe}), 32'h0000_0004);
    wr(DOPWM_OFS_ENABLE, 8'h00);
    wr(DOPWM_OFS_CTRL, 8'h80);
    rc(DOPWM_OFS_CTRL, 8'hff, 8'h80);
    chk(32'({irq_o, pri_oe, sec_oe}), 32'h0000_0000);
    $display("Test overflow flag done");
    for (int c = 0; c < 4; c++) begin
      wr(DOPWM_OFS_CTRL, 8'h10);
      wr(DOPWM_OFS_ENABLE, {1'b0, 2'(c), 5'h17});
      fault_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1 chk(32'({pri, sec}), 32'(c));
      rc(DOPWM_OFS_CTRL, 8'h20, 8'h20);
      fault_i <= 1'b0;
      wr(DOPWM_OFS_CTRL, 8'h10);
      rc(DOPWM_OFS_CTRL, 8'h20, 8'h00);
    end
    wr(DOPWM_OFS_ENABLE, 8'h07);
    fault_i <= 1'b1;
    rc(DOPWM_OFS_CTRL, 8'h20, 8'h00);
    wr(DOPWM_OFS_CTRL, 8'h00);
    fault_i <= 1'b0;
    wr(DOPWM_OFS_ENABLE, 8'h17);
    repeat (4) @(posedge clk_sys_i);
    rc(DOPWM_OFS_CTRL, 8'h20, 8'h20);
    $display("Test fault handling done");
    end_of_test();
  end
endmodule
